// *** bench/mfm_block_props.sv ***
// Port-level assertions for the multifunction memory block
`timescale 1ns/1ps
`default_nettype none

module mfm_block_props
    import mfm_pkg::*;
(
    // System and configuration
    input wire logic                  i_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_ce,
    input wire mfm_mode_t             i_mode,
    input wire logic                  i_port_a_out_async,
    input wire logic                  i_port_a_clock,
    input wire logic                  i_port_b_clock,
    // Observed outputs
    input wire logic [MFM_DATA_W-1:0] o_port_a_rdata,
    input wire logic [MFM_DATA_W-1:0] o_fifo_rdata,
    input wire logic                  o_fifo_full,
    input wire logic                  o_fifo_almost_full,
    input wire logic                  o_fifo_empty,
    input wire logic                  o_fifo_almost_empty
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    chk_reset_flags: assert property (
        $rose(i_nrst) |-> o_fifo_empty && o_fifo_almost_empty && !o_fifo_full
            && !o_fifo_almost_full && o_port_a_rdata == '0)
        else $error("outputs not at reset values");
    chk_ce_freeze: assert property (
        !i_ce |=> $stable(o_fifo_rdata) && $stable(o_port_a_rdata)
            && $stable({o_fifo_full, o_fifo_empty}))
        else $error("outputs moved with clock enable low");
    // Bench keeps the almost-full level at or below the full level
    chk_full_afull: assert property (
        i_mode == MFM_MODE_FIFO && o_fifo_full |-> o_fifo_almost_full)
        else $error("full without almost full");
    chk_empty_aempty: assert property (
        i_mode == MFM_MODE_FIFO && o_fifo_empty |-> o_fifo_almost_empty)
        else $error("empty without almost empty");
    // Pin pulses last one or four samples; update lands two or three edges later
    chk_empty_rd_edge: assert property (
        i_mode == MFM_MODE_FIFO && $fell(o_fifo_empty)
            |-> $past(i_port_b_clock, 2) || $past(i_port_b_clock, 3))
        else $error("empty cleared without read clock edge");
    chk_full_wr_edge: assert property (
        i_mode == MFM_MODE_FIFO && $rose(o_fifo_full)
            |-> $past(i_port_a_clock, 2) || $past(i_port_a_clock, 3))
        else $error("full set without write clock edge");
    chk_rdata_on_edge: assert property (
        i_mode == MFM_MODE_SINGLE && !i_port_a_out_async
            && $changed(o_port_a_rdata)
            |-> $past(i_port_a_clock, 2) || $past(i_port_a_clock, 3))
        else $error("registered read data moved without clock edge");
    chk_dual_upper: assert property (
        i_mode == MFM_MODE_DUAL
            |-> o_port_a_rdata[MFM_DATA_W-1:MFM_DP_DATA_W] == '0)
        else $error("dual mode read data wider than sixteen bits");
endmodule : mfm_block_props

`default_nettype wire

// *** bench/mfm_user_pins.sv ***
// User-logic model that drives the clock pins of the memory block
`timescale 1ns/1ps
`default_nettype none

module mfm_user_pins (
    // System
    input  wire logic i_clk,
    // Pins: port a, port b, global clocks 0 to 3
    output logic [5:0] o_clks
);
    initial o_clks = '0;

    // Low gap after each pulse, so back-to-back pulses stay separate edges
    task automatic pulse(input int idx, input bit slow);
        @(posedge i_clk) #1 o_clks[idx] = 1'b1;
        repeat (slow ? 4 : 1) @(posedge i_clk);
        #1 o_clks[idx] = 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : pulse
endmodule : mfm_user_pins

`default_nettype wire

// *** bench/tb_mfm_block.sv ***
// Self-checking bench for the multifunction memory block
`timescale 1ns/1ps
`default_nettype none

module tb_mfm_block
    import mfm_pkg::*;
;
    logic         i_clk = 1'b0;
    logic         i_nrst = 1'b0;
    logic         i_ce = 1'b1;
    mfm_mode_t    i_mode = MFM_MODE_SINGLE;
    logic [2:0]   i_port_a_width = 3'h5;
    mfm_grp_cfg_t b_cfg = '0;
    logic         a_async = 1'b0;
    logic         ahead = 1'b0;
    logic [14:0]  full_lvl = 15'h4;
    logic [14:0]  afull_lvl = 15'h3;
    logic         a_en = 1'b1;
    logic         b_en = 1'b0;
    logic         a_rst = 1'b0;
    logic         b_rst = 1'b0;
    logic         g_rst = 1'b0;
    logic         p_rst = 1'b0;
    mfm_req_t     a_req = '0;
    mfm_req_t     b_req = '0;
    logic [5:0]   clks;
    logic [31:0]  o_port_a_rdata;
    logic [31:0]  o_fifo_rdata;
    logic [15:0]  o_port_b_rdata;
    logic         o_fifo_full;
    logic         o_fifo_almost_full;
    logic         o_fifo_empty;
    logic         o_fifo_almost_empty;
    int           err_total = 0;
    int           cmp_count = 0;

    always #2 i_clk = ~i_clk;

    mfm_block uut (
        .i_clk, .i_nrst, .i_ce, .i_mode, .i_port_a_width,
        .i_port_b_width(i_port_a_width), .i_port_a_in_cfg('0),
        .i_port_a_out_cfg('0), .i_port_b_in_cfg(b_cfg), .i_port_b_out_cfg('0),
        .i_port_a_out_async(a_async), .i_port_b_out_async(1'b0),
        .i_fifo_show_ahead(ahead), .i_full_level(full_lvl),
        .i_almost_full_level(afull_lvl), .i_almost_empty_level(15'h1),
        .i_port_a_clock(clks[0]), .i_port_b_clock(clks[1]),
        .i_global_clocks_0_to_3(clks[5:2]), .i_port_a_clock_enable(a_en),
        .i_fifo_read_enable(b_en), .i_port_a_local_reset(a_rst),
        .i_port_b_local_reset(b_rst), .i_global_reset(g_rst),
        .i_fifo_read_pointer_reset(p_rst), .i_port_a_req(a_req),
        .i_port_b_req(b_req), .o_port_a_rdata, .o_port_b_rdata, .o_fifo_rdata,
        .o_fifo_full, .o_fifo_almost_full, .o_fifo_empty, .o_fifo_almost_empty
    );

    mfm_user_pins usr (
        .i_clk,
        .o_clks(clks)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rst(input mfm_mode_t m);
        @(posedge i_clk) #1 i_nrst = 1'b0;
        i_mode = m;
        repeat (2) @(posedge i_clk);
        #1 i_nrst = 1'b1;
    endtask : rst

    // Pin effects need three edges through the synchronisers
    task automatic hit(input int idx);
        usr.pulse(idx, 1'b0);
        repeat (2) @(posedge i_clk);
        #1;
    endtask : hit

    task automatic t_single;
        a_req = '{addr: 14'h3, wdata: 32'hc0de_5a5a, cs: 1'b1, wr: 1'b1};
        hit(0);
        a_en = 1'b0;
        a_req.wdata = 32'h0;
        hit(0);
        a_en = 1'b1;
        a_req.wr = 1'b0;
        hit(0);
        check(o_port_a_rdata, 32'h0);
        usr.pulse(0, 1'b1);
        hit(0);
        check(o_port_a_rdata, 32'hc0de_5a5a);
        a_async = 1'b1;
        a_req = '{addr: 14'h9, wdata: 32'h600d_f00d, cs: 1'b1, wr: 1'b1};
        hit(0);
        repeat (2) @(posedge i_clk);
        #1;
        check(o_port_a_rdata, 32'h600d_f00d);
    endtask : t_single

    task automatic t_dual;
        i_port_a_width = 3'h4;
        b_cfg.clk_src = MFM_CLK_G2;
        rst(MFM_MODE_DUAL);
        b_en = 1'b1;
        a_req = '{addr: 14'd517, wdata: 32'h1234, cs: 1'b1, wr: 1'b1};
        hit(0);
        b_req = '{addr: 14'd5, wdata: 32'h0, cs: 1'b1, wr: 1'b0};
        hit(4);
        hit(1);
        check(o_port_b_rdata, 32'h1234);
        b_rst = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        check(o_port_b_rdata, 32'h0);
        b_rst = 1'b0;
    endtask : t_dual

    task automatic t_fifo;
        i_port_a_width = 3'h5;
        b_cfg = '0;
        b_en = 1'b0;
        rst(MFM_MODE_FIFO);
        for (int k = 0; k < 5; k++) begin
            a_req.wdata = 32'h10 + k;
            hit(0);
            check(o_fifo_almost_full, k >= 2);
            check(o_fifo_full, k >= 3);
        end
        hit(1);
        check(o_fifo_empty, 1'b0);
        b_en = 1'b1;
        for (int k = 0; k < 5; k++) begin
            hit(1);
            check(o_fifo_rdata, 32'h10 + (k > 3 ? 3 : k));
            check(o_fifo_almost_empty, k >= 2);
            check(o_fifo_empty, k >= 3);
        end
        b_en = 1'b0;
        p_rst = 1'b1;
        hit(1);
        p_rst = 1'b0;
        b_en = 1'b1;
        hit(1);
        check(o_fifo_rdata, 32'h10);
        g_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        check(o_fifo_full, 1'b0);
        g_rst = 1'b0;
        i_ce = 1'b0;
        hit(0);
        i_ce = 1'b1;
        hit(1);
        check(o_fifo_empty, 1'b1);
    endtask : t_fifo

    task automatic t_ahead;
        ahead = 1'b1;
        full_lvl = 15'h1;
        afull_lvl = 15'h1;
        b_en = 1'b0;
        rst(MFM_MODE_FIFO);
        a_req.wdata = 32'h77;
        hit(0);
        a_req.wdata = 32'h88;
        hit(0);
        check(o_fifo_full, 1'b1);
        hit(1);
        check(o_fifo_rdata, 32'h77);
        a_rst = 1'b1;
        hit(1);
        check(o_fifo_empty, 1'b1);
    endtask : t_ahead

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        t_single;
        t_dual;
        t_fifo;
        t_ahead;
        tally_and_finish;
    end

    // Far beyond the 28 pin pulses the scenarios need
    initial begin
        #50000;
        err_total++;
        tally_and_finish;
    end
endmodule : tb_mfm_block

bind mfm_block mfm_block_props chk (
    .i_clk, .i_nrst, .i_ce, .i_mode, .i_port_a_out_async, .i_port_a_clock,
    .i_port_b_clock, .o_port_a_rdata, .o_fifo_rdata, .o_fifo_full,
    .o_fifo_almost_full, .o_fifo_empty, .o_fifo_almost_empty
);

`default_nettype wire

// *** logic/mfm_block.sv ***
// Multifunction memory block: dual-port, single-port and FIFO modes
`timescale 1ns/1ps
`default_nettype none

module mfm_block
    import mfm_pkg::*;
#(
    parameter int MEM_WORDS = MFM_WORDS
) (
    // System
    input  wire logic                     i_clk,
    input  wire logic                     i_nrst,
    input  wire logic                     i_ce,
    // Configuration
    input  wire mfm_mode_t                i_mode,
    input  wire logic [MFM_WC_W-1:0]      i_port_a_width,
    input  wire logic [MFM_WC_W-1:0]      i_port_b_width,
    input  wire mfm_grp_cfg_t             i_port_a_in_cfg,
    input  wire mfm_grp_cfg_t             i_port_a_out_cfg,
    input  wire mfm_grp_cfg_t             i_port_b_in_cfg,
    input  wire mfm_grp_cfg_t             i_port_b_out_cfg,
    input  wire logic                     i_port_a_out_async,
    input  wire logic                     i_port_b_out_async,
    input  wire logic                     i_fifo_show_ahead,
    input  wire logic [MFM_CNT_W-1:0]     i_full_level,
    input  wire logic [MFM_CNT_W-1:0]     i_almost_full_level,
    input  wire logic [MFM_CNT_W-1:0]     i_almost_empty_level,
    // Clock, enable and reset pins
    input  wire logic                     i_port_a_clock,
    input  wire logic                     i_port_b_clock,
    input  wire logic [3:0]               i_global_clocks_0_to_3,
    input  wire logic                     i_port_a_clock_enable,
    input  wire logic                     i_fifo_read_enable,
    input  wire logic                     i_port_a_local_reset,
    input  wire logic                     i_port_b_local_reset,
    input  wire logic                     i_global_reset,
    input  wire logic                     i_fifo_read_pointer_reset,
    // Port requests
    input  wire mfm_req_t                 i_port_a_req,
    input  wire mfm_req_t                 i_port_b_req,
    // Read data and flags
    output logic [MFM_DATA_W-1:0]         o_port_a_rdata,
    output logic [MFM_DP_DATA_W-1:0]      o_port_b_rdata,
    output logic [MFM_DATA_W-1:0]         o_fifo_rdata,
    output logic                          o_fifo_full,
    output logic                          o_fifo_almost_full,
    output logic                          o_fifo_empty,
    output logic                          o_fifo_almost_empty
);

    logic [MFM_DATA_W-1:0] mem [MEM_WORDS];

    mfm_top_st_t  st_q;
    mfm_top_st_t  st_d;
    mfm_pins_t    pins;
    mfm_grp_evt_t ev_ai;
    mfm_grp_evt_t ev_ao;
    mfm_grp_evt_t ev_bi;
    mfm_grp_evt_t ev_bo;
    mfm_grp_cfg_t cfg_ao;
    mfm_grp_cfg_t cfg_bi;
    mfm_grp_cfg_t cfg_bo;
    logic         b_loc_rst;
    logic         dual;
    logic         fifo;

    // Write path into the array
    logic                   wa_en;
    logic                   wb_en;
    logic [MFM_OFF_W-1:0]   wa_off;
    logic [MFM_OFF_W-1:0]   wb_off;
    logic [MFM_DATA_W-1:0]  wa_new;
    logic [MFM_DATA_W-1:0]  wb_new;
    logic [MFM_DATA_W-1:0]  wb_base;
    logic [MFM_WC_W-1:0]    a_wc;
    logic [MFM_WC_W-1:0]    b_wc;
    logic [MFM_CNT_W-1:0]   cap;
    logic [MFM_CNT_W-1:0]   full_lim;
    logic                   push;
    logic                   pop;

    // Width 1 << wc as a low-aligned mask
    function automatic logic [MFM_DATA_W-1:0] lane_mask(
        input logic [MFM_WC_W-1:0] wc
    );
        logic [63:0] m;
        m = (64'h1 << (7'h1 << wc)) - 64'h1;
        return m[MFM_DATA_W-1:0];
    endfunction : lane_mask

    function automatic logic [MFM_OFF_W-1:0] bit_off(
        input logic [MFM_OFF_W-1:0] idx,
        input logic [MFM_WC_W-1:0]  wc,
        input logic                 dp
    );
        logic [MFM_OFF_W-1:0] o;
        o = idx << wc;
        return dp ? (o & MFM_DP_OFF_MSK) : o;
    endfunction : bit_off

    function automatic logic [MFM_DATA_W-1:0] mem_rd(
        input logic [MFM_OFF_W-1:0] off,
        input logic [MFM_WC_W-1:0]  wc
    );
        logic [MFM_DATA_W-1:0] w;
        w = mem[off[MFM_OFF_W-1:MFM_LANE_W]];
        return (w >> off[MFM_LANE_W-1:0]) & lane_mask(wc);
    endfunction : mem_rd

    function automatic logic [MFM_DATA_W-1:0] merge(
        input logic [MFM_DATA_W-1:0] old,
        input logic [MFM_OFF_W-1:0]  off,
        input logic [MFM_WC_W-1:0]   wc,
        input logic [MFM_DATA_W-1:0] data
    );
        logic [MFM_DATA_W-1:0] m;
        m = lane_mask(wc) << off[MFM_LANE_W-1:0];
        return (old & ~m) | ((data << off[MFM_LANE_W-1:0]) & m);
    endfunction : merge

    assign dual = (i_mode == MFM_MODE_DUAL);
    assign fifo = (i_mode == MFM_MODE_FIFO);

    // Single mode runs every group from the port A input settings; FIFO runs the read groups from port B input settings
    assign cfg_ao    = dual ? i_port_a_out_cfg : i_port_a_in_cfg;
    assign cfg_bi    = dual || fifo ? i_port_b_in_cfg : i_port_a_in_cfg;
    assign cfg_bo    = dual ? i_port_b_out_cfg : cfg_bi;
    assign b_loc_rst = dual ? st_q.sync2.b_rst : st_q.sync2.a_rst;

    assign pins = '{
        a_clk:    i_port_a_clock,
        b_clk:    i_port_b_clock,
        glb_clk:  i_global_clocks_0_to_3,
        a_en:     i_port_a_clock_enable,
        b_en:     i_fifo_read_enable,
        a_rst:    i_port_a_local_reset,
        b_rst:    i_port_b_local_reset,
        g_rst:    i_global_reset,
        rptr_rst: i_fifo_read_pointer_reset
    };

    // Group selection units
    mfm_clk_sel u_sel_ai (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_ce      (i_ce),
        .i_ded_clk (st_q.sync2.a_clk),
        .i_glb_clk (st_q.sync2.glb_clk),
        .i_ded_en  (st_q.sync2.a_en),
        .i_loc_rst (st_q.sync2.a_rst),
        .i_glb_rst (st_q.sync2.g_rst),
        .i_cfg     (i_port_a_in_cfg),
        .o_evt     (ev_ai)
    );

    mfm_clk_sel u_sel_ao (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_ce      (i_ce),
        .i_ded_clk (st_q.sync2.a_clk),
        .i_glb_clk (st_q.sync2.glb_clk),
        .i_ded_en  (st_q.sync2.a_en),
        .i_loc_rst (st_q.sync2.a_rst),
        .i_glb_rst (st_q.sync2.g_rst),
        .i_cfg     (cfg_ao),
        .o_evt     (ev_ao)
    );

    mfm_clk_sel u_sel_bi (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_ce      (i_ce),
        .i_ded_clk (dual || fifo ? st_q.sync2.b_clk : st_q.sync2.a_clk),
        .i_glb_clk (st_q.sync2.glb_clk),
        .i_ded_en  (dual || fifo ? st_q.sync2.b_en : st_q.sync2.a_en),
        .i_loc_rst (b_loc_rst),
        .i_glb_rst (st_q.sync2.g_rst),
        .i_cfg     (cfg_bi),
        .o_evt     (ev_bi)
    );

    mfm_clk_sel u_sel_bo (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_ce      (i_ce),
        .i_ded_clk (dual || fifo ? st_q.sync2.b_clk : st_q.sync2.a_clk),
        .i_glb_clk (st_q.sync2.glb_clk),
        .i_ded_en  (dual || fifo ? st_q.sync2.b_en : st_q.sync2.a_en),
        .i_loc_rst (b_loc_rst),
        .i_glb_rst (st_q.sync2.g_rst),
        .i_cfg     (cfg_bo),
        .o_evt     (ev_bo)
    );

    always_comb begin
        // Width codes clamp to what each mode offers
        if (dual) begin
            a_wc = (i_port_a_width > MFM_WC_MAX_DP) ? MFM_WC_MAX_DP
                                                    : i_port_a_width;
            b_wc = (i_port_b_width > MFM_WC_MAX_DP) ? MFM_WC_MAX_DP
                                                    : i_port_b_width;
        end else begin
            a_wc = (i_port_a_width > MFM_WC_MAX_SP) ? MFM_WC_MAX_SP
                                                    : i_port_a_width;
            b_wc = a_wc;
        end

        cap      = MFM_CNT_W'(MFM_MEM_BITS) >> a_wc;
        // Zero or oversized level falls back to the true capacity
        full_lim = (i_full_level == '0 || i_full_level > cap) ? cap
                                                              : i_full_level;
        push = fifo && ev_ai.tick && (st_q.count < full_lim);
        pop  = fifo && ev_bi.tick && (st_q.count != '0);

        wa_en  = fifo ? push : st_q.a_wpend;
        wa_off = fifo ? bit_off(st_q.wptr, a_wc, 1'b0)
                      : bit_off(st_q.a_req.addr, a_wc, dual);
        wa_new = merge(mem[wa_off[MFM_OFF_W-1:MFM_LANE_W]], wa_off, a_wc,
                       fifo ? i_port_a_req.wdata : st_q.a_req.wdata);
        wb_en  = dual && st_q.b_wpend;
        wb_off = bit_off(st_q.b_req.addr, b_wc, 1'b1);
        // Same-word writes from both ports merge rather than clobber
        wb_base = (wa_en && wa_off[MFM_OFF_W-1:MFM_LANE_W]
                             == wb_off[MFM_OFF_W-1:MFM_LANE_W])
                  ? wa_new : mem[wb_off[MFM_OFF_W-1:MFM_LANE_W]];
        wb_new  = merge(wb_base, wb_off, b_wc, st_q.b_req.wdata);
    end

    always_comb begin
        st_d       = st_q;
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;

        // Port A: requests held in registers outside FIFO mode, where write data passes straight through
        if (ev_ai.tick && !fifo) begin
            st_d.a_req = i_port_a_req;
        end
        st_d.a_wpend = ev_ai.tick && !fifo && i_port_a_req.cs
                       && i_port_a_req.wr;
        if (!fifo && i_port_a_out_async) begin
            st_d.a_rdata = mem_rd(bit_off(st_q.a_req.addr, a_wc, dual), a_wc);
        end else if (!fifo && ev_ao.tick && st_q.a_req.cs && !st_q.a_req.wr) begin
            st_d.a_rdata = mem_rd(bit_off(st_q.a_req.addr, a_wc, dual), a_wc);
        end
        if (ev_ai.rst) begin
            st_d.a_req   = '0;
            st_d.a_wpend = 1'b0;
        end
        if (ev_ao.rst) begin
            st_d.a_rdata = '0;
        end

        // Port B exists in dual mode only
        if (ev_bi.tick && dual) begin
            st_d.b_req = i_port_b_req;
        end
        st_d.b_wpend = ev_bi.tick && dual && i_port_b_req.cs
                       && i_port_b_req.wr;
        if (dual && (i_port_b_out_async || (ev_bo.tick && st_q.b_req.cs
                                            && !st_q.b_req.wr))) begin
            st_d.b_rdata = MFM_DP_DATA_W'(mem_rd(wb_off, b_wc));
        end
        if (ev_bi.rst) begin
            st_d.b_req   = '0;
            st_d.b_wpend = 1'b0;
        end
        if (ev_bo.rst) begin
            st_d.b_rdata = '0;
        end

        // FIFO pointers and level
        if (push) begin
            st_d.wptr = (MFM_CNT_W'(st_q.wptr) + 15'h1 == cap)
                        ? '0 : st_q.wptr + 14'h1;
        end
        if (pop) begin
            st_d.f_rdata = mem_rd(bit_off(st_q.rptr, a_wc, 1'b0), a_wc);
            st_d.rptr    = (MFM_CNT_W'(st_q.rptr) + 15'h1 == cap)
                           ? '0 : st_q.rptr + 14'h1;
        end
        st_d.count = st_q.count + MFM_CNT_W'(push) - MFM_CNT_W'(pop);
        // Replays everything written since the last wrap of the write side
        if (fifo && ev_bi.clk_edge && st_q.sync2.rptr_rst) begin
            st_d.rptr  = '0;
            st_d.count = MFM_CNT_W'(st_d.wptr);
        end
        // Show-ahead: next entry sits on the output before it is read
        if (fifo && i_fifo_show_ahead && ev_bi.clk_edge) begin
            st_d.f_rdata = mem_rd(bit_off(st_d.rptr, a_wc, 1'b0), a_wc);
        end

        // Flags follow their own side's clock edge
        if (fifo && ev_ai.clk_edge) begin
            st_d.full  = st_d.count >= full_lim;
            st_d.afull = st_d.count >= i_almost_full_level;
        end
        if (fifo && ev_bi.clk_edge) begin
            st_d.empty  = st_d.count == '0;
            st_d.aempty = st_d.count <= i_almost_empty_level;
        end

        // Write-side reset clears pointers, level, flags and read data
        if (fifo && ev_ai.rst) begin
            st_d.wptr    = '0;
            st_d.rptr    = '0;
            st_d.count   = '0;
            st_d.full    = 1'b0;
            st_d.afull   = 1'b0;
            st_d.empty   = 1'b1;
            st_d.aempty  = 1'b1;
            st_d.f_rdata = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= MFM_ST_RST;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // Array contents are not reset
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (wa_en) begin
                mem[wa_off[MFM_OFF_W-1:MFM_LANE_W]] <= wa_new;
            end
            if (wb_en) begin
                mem[wb_off[MFM_OFF_W-1:MFM_LANE_W]] <= wb_new;
            end
        end
    end

    assign o_port_a_rdata      = st_q.a_rdata;
    assign o_port_b_rdata      = st_q.b_rdata;
    assign o_fifo_rdata        = st_q.f_rdata;
    assign o_fifo_full         = st_q.full;
    assign o_fifo_almost_full  = st_q.afull;
    assign o_fifo_empty        = st_q.empty;
    assign o_fifo_almost_empty = st_q.aempty;

endmodule : mfm_block

`default_nettype wire

// *** logic/mfm_clk_sel.sv ***
// Clock, enable and reset selection for one register group
`timescale 1ns/1ps
`default_nettype none

module mfm_clk_sel
    import mfm_pkg::*;
(
    // System
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    // Synchronised sources
    input  wire logic         i_ded_clk,
    input  wire logic [3:0]   i_glb_clk,
    input  wire logic         i_ded_en,
    input  wire logic         i_loc_rst,
    input  wire logic         i_glb_rst,
    // Selection
    input  wire mfm_grp_cfg_t i_cfg,
    // Events
    output mfm_grp_evt_t      o_evt
);

    mfm_sel_st_t st_q;
    mfm_sel_st_t st_d;
    logic        lvl;
    logic        en;

    always_comb begin
        unique case (i_cfg.clk_src)
            MFM_CLK_DED: lvl = i_ded_clk;
            MFM_CLK_G0:  lvl = i_glb_clk[0];
            MFM_CLK_G1:  lvl = i_glb_clk[1];
            MFM_CLK_G2:  lvl = i_glb_clk[2];
            MFM_CLK_G3:  lvl = i_glb_clk[3];
            default:     lvl = i_ded_clk;
        endcase
        lvl = lvl ^ i_cfg.clk_inv;
        unique case (i_cfg.en_src)
            MFM_EN_DED: en = i_ded_en;
            MFM_EN_G1:  en = i_glb_clk[1];
            MFM_EN_G2:  en = i_glb_clk[2];
            default:    en = i_ded_en;
        endcase
        en = en ^ i_cfg.en_inv;
        // Raw level kept: an inverted idle clock gives no edge after reset
        st_d.clk_lvl = lvl ^ i_cfg.clk_inv;
        // Rising edge of the chosen, possibly inverted, clock
        o_evt.clk_edge = lvl & ~(st_q.clk_lvl ^ i_cfg.clk_inv);
        o_evt.tick     = o_evt.clk_edge & en;
        // Acts at once, not on the group clock
        o_evt.rst      = i_glb_rst | (i_loc_rst ^ i_cfg.rst_inv);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

endmodule : mfm_clk_sel

`default_nettype wire

// *** shared/mfm_pkg.sv ***
// Shared constants and types of the multifunction memory block
package mfm_pkg;

    // Array geometry
    localparam int MFM_MEM_BITS   = 16384;
    localparam int MFM_DATA_W     = 32;
    localparam int MFM_DP_DATA_W  = 16;
    localparam int MFM_OFF_W      = 14;
    localparam int MFM_LANE_W     = 5;
    localparam int MFM_WORDS      = MFM_MEM_BITS / MFM_DATA_W;
    localparam int MFM_WORD_AW    = 9;
    localparam int MFM_CNT_W      = 15;
    localparam int MFM_WC_W       = 3;

    // Width codes: width is 1 << code
    localparam logic [2:0]  MFM_WC_MAX_SP  = 3'h5;
    localparam logic [2:0]  MFM_WC_MAX_DP  = 3'h4;
    localparam logic [13:0] MFM_DP_OFF_MSK = 14'h1fff;

    typedef enum logic [1:0] {
        MFM_MODE_DUAL,
        MFM_MODE_SINGLE,
        MFM_MODE_FIFO
    } mfm_mode_t;

    typedef enum logic [2:0] {
        MFM_CLK_DED,
        MFM_CLK_G0,
        MFM_CLK_G1,
        MFM_CLK_G2,
        MFM_CLK_G3
    } mfm_clk_src_t;

    typedef enum logic [1:0] {
        MFM_EN_DED,
        MFM_EN_G1,
        MFM_EN_G2
    } mfm_en_src_t;

    // Clock, enable and reset selection of one register group
    typedef struct packed {
        mfm_clk_src_t clk_src;
        logic         clk_inv;
        mfm_en_src_t  en_src;
        logic         en_inv;
        logic         rst_inv;
    } mfm_grp_cfg_t;

    // Per-cycle events of one register group
    typedef struct packed {
        logic clk_edge;
        logic tick;
        logic rst;
    } mfm_grp_evt_t;

    // One memory port request from user logic
    typedef struct packed {
        logic [MFM_OFF_W-1:0]  addr;
        logic [MFM_DATA_W-1:0] wdata;
        logic                  cs;
        logic                  wr;
    } mfm_req_t;

    // Pins arriving from outside the clock domain
    typedef struct packed {
        logic       a_clk;
        logic       b_clk;
        logic [3:0] glb_clk;
        logic       a_en;
        logic       b_en;
        logic       a_rst;
        logic       b_rst;
        logic       g_rst;
        logic       rptr_rst;
    } mfm_pins_t;

    typedef struct packed {
        logic clk_lvl;
    } mfm_sel_st_t;

    typedef struct packed {
        mfm_pins_t                sync1;
        mfm_pins_t                sync2;
        mfm_req_t                 a_req;
        logic                     a_wpend;
        logic [MFM_DATA_W-1:0]    a_rdata;
        mfm_req_t                 b_req;
        logic                     b_wpend;
        logic [MFM_DP_DATA_W-1:0] b_rdata;
        logic [MFM_OFF_W-1:0]     wptr;
        logic [MFM_OFF_W-1:0]     rptr;
        logic [MFM_CNT_W-1:0]     count;
        logic                     full;
        logic                     afull;
        logic                     empty;
        logic                     aempty;
        logic [MFM_DATA_W-1:0]    f_rdata;
    } mfm_top_st_t;

    localparam mfm_top_st_t MFM_ST_RST = '{
        empty:   1'b1,
        aempty:  1'b1,
        default: '0
    };

endpackage : mfm_pkg
